// [core/mtsa_defines.vh]
// Constants for the multi-tile synchronization alignment block
// Overview of operation
// RULE1: Timing reference and fabric clock groups keep fixed phase over resets.
// RULE2: Reference routed to selected tiles and scanned over one sample period.
// RULE3: With a forwarded clock only source tiles are scanned; source is reference.
// RULE4: Without clock forwarding the reference tile defaults to tile zero. The code takes the reference tile from ref_tile instead.
// RULE5: Distribute reference, choose capture tap, then align tile FIFOs.
// RULE6: Stable taps scan as zero; edge taps scan as one, two or three.
// RULE7: Reference tile scan starts at midpoint tap of the chain.
// RULE8: Reference tile safe tap seeds the scans of later tiles. The code seeds each scan from the safe tap of the tile scanned just before it.
// RULE9: Too long a run of edge taps ends with a scan failure.
// RULE10: Report marker counter value and FIFO marker word per tile.
// RULE11: Marker position beyond FIFO width means over/underflow or bad clocking.
// RULE12: Fabric reference period is reported as a count of sample periods.
// RULE13: Target latency is the largest latency; all tiles then show it.
// RULE14: Latency is measured across the FIFO, reference to reference.
// RULE15: PLL-stage scan runs only on the PLL of the source tile.
// RULE16: An optional target delay forces a fixed latency, set with margin.
// RULE17: FIFO offset grows by target minus measured latency, in fabric words.
`ifndef MTSA_DEFINES_VH
`define MTSA_DEFINES_VH
`define MTSA_TILES 4
`define MTSA_TAPS 128
`define MTSA_TAP_MID 7'h40
`define MTSA_TAP_W 7
`define MTSA_EDGE_MAX 8'h10
`define MTSA_LAT_W 12
`define MTSA_FIFO_WIDTH 4'hc
`define MTSA_SETTLE 4'h8
`define MTSA_TIMEOUT 16'hffff
`endif

// [core/mtsa_scan_mem.v]
// Scan result memory, one two-bit code per tap, registered read
`timescale 1ns/10ps
`include "mtsa_defines.vh"
module mtsa_scan_mem
(
   // Clock
   input wire sys_clk,
   // Write port
   input wire wr_en,
   input wire [6:0] wr_addr,
   input wire [1:0] wr_data,
   // Read port
   input wire [6:0] rd_addr,
   output reg [1:0] rd_data
);
   reg [1:0] mem [0:`MTSA_TAPS-1];
   always @(posedge sys_clk)
   begin
      if (wr_en)
         mem[wr_addr] <= wr_data;
      rd_data <= mem[rd_addr];
   end
endmodule

// [core/mtsa_top.v]
// Multi-tile synchronization sequencer: tap scan, marker report, alignment
`timescale 1ns/10ps
`include "mtsa_defines.vh"
module mtsa_top
(
   // Clock and reset
   input wire sys_clk,
   input wire reset_n,
   // Control
   input wire sync_start,
   input wire [3:0] tile_sel,
   input wire [1:0] ref_tile,
   input wire clk_forward,
   input wire [3:0] clk_source_mask,
   input wire pll_mode,
   input wire [11:0] target_delay,
   // Delay tap chain interface, one sample from the selected tile
   output reg [6:0] chain_tap,
   output reg [1:0] chain_tile,
   output reg chain_pll_stage,
   output reg ref_route_en,
   input wire [1:0] chain_sample,
   input wire chain_sample_vld,
   // Per-tile FIFO marker measurement
   input wire [15:0] marker_count,
   input wire [3:0] marker_word,
   input wire [11:0] tile_latency,
   input wire meas_vld,
   // Fabric reference period in sample periods
   input wire [11:0] fabric_ref_period,
   // Results
   output reg [1:0] rpt_tile,
   output reg [15:0] rpt_marker_count,
   output reg [3:0] rpt_marker_word,
   output reg rpt_marker_bad,
   output reg [11:0] rpt_offset,
   output reg [6:0] rpt_tap,
   output reg rpt_vld,
   output reg [11:0] rpt_ref_period,
   output reg [11:0] target_latency,
   output reg fifo_adj_vld,
   output reg [1:0] fifo_adj_tile,
   output reg [11:0] fifo_adj_offset,
   output reg busy,
   output reg done,
   output reg scan_fail
);
   localparam S_IDLE = 4'h0;
   localparam S_NEXT = 4'h1;
   localparam S_SCAN = 4'h2;
   localparam S_WAIT = 4'h3;
   localparam S_EVAL = 4'h4;
   localparam S_MEAS = 4'h5;
   localparam S_ALIGN = 4'h6;
   localparam S_DONE = 4'h7;
   localparam S_FAIL = 4'h8;
   localparam S_READ = 4'h9;

   reg [3:0] state_q;
   reg [1:0] tile_q;
   reg [3:0] todo_q;
   reg [3:0] scanned_q;
   reg [6:0] tap_q;
   reg [6:0] cnt_q;
   reg [6:0] safe_tap_q;
   reg seed_q;
   reg [7:0] run_q;
   reg [7:0] best_len_q;
   reg [6:0] best_start_q;
   reg [7:0] zrun_q;
   reg [6:0] zstart_q;
   reg [3:0] settle_q;
   reg [15:0] tmo_q;
   reg [11:0] lat_q [0:3];
   reg [11:0] max_q;
   reg [1:0] eff_ref_q;
   wire wr_en = (state_q == S_WAIT) && (settle_q == 4'h0) &&
      (tmo_q != `MTSA_TIMEOUT) && chain_sample_vld;
   wire [1:0] mem_rd;
   integer i;

   function [3:0] onehot;
      input [1:0] idx;
      begin
         onehot = 4'h1 << idx;
      end
   endfunction

   function [1:0] first_set;
      input [3:0] m;
      begin
         first_set = m[0] ? 2'h0 : m[1] ? 2'h1 : m[2] ? 2'h2 : 2'h3;
      end
   endfunction

   // Scan result store
   mtsa_scan_mem u_mem
   (
      .sys_clk(sys_clk),
      .wr_en(wr_en),
      .wr_addr(tap_q),
      .wr_data(chain_sample),
      .rd_addr(tap_q),
      .rd_data(mem_rd)
   );

   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         state_q <= S_IDLE;
         tile_q <= 2'h0;
         todo_q <= 4'h0;
         scanned_q <= 4'h0;
         tap_q <= 7'h0;
         cnt_q <= 7'h0;
         safe_tap_q <= 7'h0;
         seed_q <= 1'b0;
         run_q <= 8'h0;
         best_len_q <= 8'h0;
         best_start_q <= 7'h0;
         zrun_q <= 8'h0;
         zstart_q <= 7'h0;
         settle_q <= 4'h0;
         tmo_q <= 16'h0;
         max_q <= 12'h0;
         eff_ref_q <= 2'h0;
         for (i = 0; i < 4; i = i + 1)
            lat_q[i] <= 12'h0;
         chain_tap <= 7'h0;
         chain_tile <= 2'h0;
         chain_pll_stage <= 1'b0;
         ref_route_en <= 1'b0;
         rpt_tile <= 2'h0;
         rpt_marker_count <= 16'h0;
         rpt_marker_word <= 4'h0;
         rpt_marker_bad <= 1'b0;
         rpt_offset <= 12'h0;
         rpt_tap <= 7'h0;
         rpt_vld <= 1'b0;
         rpt_ref_period <= 12'h0;
         target_latency <= 12'h0;
         fifo_adj_vld <= 1'b0;
         fifo_adj_tile <= 2'h0;
         fifo_adj_offset <= 12'h0;
         busy <= 1'b0;
         done <= 1'b0;
         scan_fail <= 1'b0;
      end
      else
      begin
         rpt_vld <= 1'b0;
         fifo_adj_vld <= 1'b0;
         done <= 1'b0;
         case (state_q)
            S_IDLE:
            begin
               if (sync_start && (tile_sel != 4'h0))
               begin
                  // RULE4: reference tile taken from ref_tile, not tile zero
                  // RULE3: forwarding picks source
                  eff_ref_q <= clk_forward ?
                     first_set(clk_source_mask) : ref_tile;
                  // RULE2: scan selected tiles
                  todo_q <= clk_forward ?
                     (tile_sel & clk_source_mask) : tile_sel;
                  scanned_q <= 4'h0;
                  seed_q <= 1'b0;
                  busy <= 1'b1;
                  scan_fail <= 1'b0;
                  // RULE5: distribute reference first
                  ref_route_en <= 1'b1;
                  max_q <= 12'h0;
                  state_q <= S_NEXT;
               end
            end
            S_NEXT:
            begin
               if (todo_q == 4'h0)
               begin
                  tile_q <= first_set(tile_sel);
                  state_q <= S_MEAS;
               end
               else
               begin
                  // Reference tile scanned first whenever it is still in the scan list
                  tile_q <= (todo_q & onehot(eff_ref_q)) != 4'h0 ?
                     eff_ref_q : first_set(todo_q);
                  // RULE7: midpoint start
                  // RULE8: seed from safe tap
                  tap_q <= seed_q ? safe_tap_q : `MTSA_TAP_MID;
                  cnt_q <= 7'h0;
                  run_q <= 8'h0;
                  zrun_q <= 8'h0;
                  best_len_q <= 8'h0;
                  state_q <= S_SCAN;
               end
            end
            S_SCAN:
            begin
               chain_tile <= tile_q;
               chain_tap <= tap_q;
               // RULE15: PLL stage on source only
               chain_pll_stage <= pll_mode && clk_forward &&
                  (tile_q == eff_ref_q);
               settle_q <= `MTSA_SETTLE;
               tmo_q <= 16'h0;
               state_q <= S_WAIT;
            end
            S_WAIT:
            begin
               tmo_q <= tmo_q + 16'h1;
               if (tmo_q == `MTSA_TIMEOUT)
                  state_q <= S_FAIL;
               else if (settle_q != 4'h0)
                  settle_q <= settle_q - 4'h1;
               else if (chain_sample_vld)
                  state_q <= S_READ;
            end
            S_READ:
               state_q <= S_EVAL;
            S_EVAL:
            begin
               // RULE6: zero stable, nonzero edge
               if (mem_rd == 2'h0)
               begin
                  run_q <= 8'h0;
                  if (zrun_q == 8'h0)
                     zstart_q <= tap_q;
                  if (zrun_q + 8'h1 > best_len_q)
                  begin
                     best_len_q <= zrun_q + 8'h1;
                     best_start_q <= (zrun_q == 8'h0) ? tap_q : zstart_q;
                  end
                  zrun_q <= zrun_q + 8'h1;
               end
               else
               begin
                  zrun_q <= 8'h0;
                  run_q <= run_q + 8'h1;
               end
               // RULE9: excessive jitter fails
               if ((mem_rd != 2'h0) && (run_q + 8'h1 >= `MTSA_EDGE_MAX))
                  state_q <= S_FAIL;
               else if (cnt_q == 7'h7f)
               begin
                  if (best_len_q == 8'h0 && mem_rd != 2'h0)
                     state_q <= S_FAIL;
                  else
                  begin
                     safe_tap_q <= (mem_rd == 2'h0 && zrun_q + 8'h1 >
                        best_len_q) ? tap_q : best_start_q;
                     seed_q <= 1'b1;
                     rpt_tile <= tile_q;
                     rpt_tap <= best_start_q;
                     scanned_q <= scanned_q | onehot(tile_q);
                     todo_q <= todo_q & ~onehot(tile_q);
                     state_q <= S_NEXT;
                  end
               end
               else
               begin
                  cnt_q <= cnt_q + 7'h1;
                  tap_q <= tap_q + 7'h1;
                  state_q <= S_SCAN;
               end
            end
            S_MEAS:
            begin
               if ((tile_sel & onehot(tile_q)) == 4'h0)
                  tile_q <= tile_q + 2'h1;
               else if (meas_vld)
               begin
                  // RULE10: marker report
                  rpt_tile <= tile_q;
                  rpt_marker_count <= marker_count;
                  rpt_marker_word <= marker_word;
                  // RULE11: flag beyond FIFO width
                  rpt_marker_bad <= marker_word > `MTSA_FIFO_WIDTH;
                  rpt_vld <= 1'b1;
                  // RULE14: latency across FIFO
                  lat_q[tile_q] <= tile_latency;
                  if (tile_latency > max_q)
                     max_q <= tile_latency;
                  if (tile_q == 2'h3 || (tile_sel >> tile_q) == 4'h1)
                  begin
                     // RULE12: reference period in samples
                     rpt_ref_period <= fabric_ref_period;
                     tile_q <= 2'h0;
                     state_q <= S_ALIGN;
                  end
                  else
                     tile_q <= tile_q + 2'h1;
               end
            end
            S_ALIGN:
            begin
               // RULE13: target is largest latency
               // RULE16: optional forced target
               target_latency <= (target_delay > max_q) ?
                  target_delay : max_q;
               if ((tile_sel & onehot(tile_q)) != 4'h0)
               begin
                  // RULE17: offset raised by difference
                  fifo_adj_offset <= ((target_delay > max_q) ?
                     target_delay : max_q) - lat_q[tile_q];
                  rpt_offset <= ((target_delay > max_q) ?
                     target_delay : max_q) - lat_q[tile_q];
                  fifo_adj_tile <= tile_q;
                  fifo_adj_vld <= 1'b1;
               end
               if (tile_q == 2'h3)
                  state_q <= S_DONE;
               tile_q <= tile_q + 2'h1;
            end
            S_DONE:
            begin
               busy <= 1'b0;
               ref_route_en <= 1'b0;
               chain_pll_stage <= 1'b0;
               done <= 1'b1;
               state_q <= S_IDLE;
            end
            S_FAIL:
            begin
               busy <= 1'b0;
               ref_route_en <= 1'b0;
               chain_pll_stage <= 1'b0;
               scan_fail <= 1'b1;
               done <= 1'b1;
               state_q <= S_IDLE;
            end
            default:
               state_q <= S_IDLE;
         endcase
      end
   end
endmodule

// [bench/mtsa_far_model.sv]
// Far-side model: tap chain samples and FIFO measurements
`timescale 1ns/10ps
module mtsa_far_model
(
   // Clock and reset
   input wire sys_clk,
   input wire reset_n,
   // Scan side
   input wire [6:0] chain_tap,
   input wire [1:0] chain_tile,
   input wire [4:0] edge_len,
   output wire [1:0] chain_sample,
   output wire chain_sample_vld,
   // Measurement side
   input wire busy,
   input wire rpt_vld,
   output wire [15:0] marker_count,
   output wire [3:0] marker_word,
   output wire [11:0] tile_latency,
   output reg meas_vld
);
   reg [8:0] pos_q;
   reg [3:0] cnt_q;
   reg [3:0] tick_q;
   reg [1:0] k_q;
   wire [6:0] rel = chain_tap - 7'h50;
   assign chain_sample_vld = cnt_q > 4'h8;
   assign chain_sample = !chain_sample_vld ? cnt_q[1:0] :
      (rel < {2'h0, edge_len}) ? (rel[1:0] | 2'h1) : 2'h0;
   assign marker_word = 4'ha + {1'b0, k_q, 1'b0};
   assign marker_count = 16'h0009 + {14'h0, k_q};
   assign tile_latency = 12'h064 + {7'h0, k_q, 3'h0};
   always @(posedge sys_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pos_q <= 9'h0;
         cnt_q <= 4'h0;
         tick_q <= 4'h0;
         k_q <= 2'h0;
         meas_vld <= 1'b0;
      end
      else
      begin
         pos_q <= {chain_tile, chain_tap};
         if (pos_q != {chain_tile, chain_tap})
            cnt_q <= 4'h0;
         else if (cnt_q != 4'hf)
            cnt_q <= cnt_q + 4'h1;
         tick_q <= busy ? tick_q + 4'h1 : 4'h0;
         meas_vld <= busy && tick_q == 4'hf;
         if (!busy)
            k_q <= 2'h0;
         else if (rpt_vld)
            k_q <= k_q + 2'h1;
      end
   end
endmodule

// [bench/mtsa_top_sva.sv]
// Checker for the synchronization sequencer ports
`timescale 1ns/10ps
module mtsa_top_sva
(
   // Clock, reset, controls
   input wire sys_clk,
   input wire reset_n,
   input wire sync_start,
   input wire [3:0] tile_sel,
   input wire [1:0] ref_tile,
   input wire clk_forward,
   input wire pll_mode,
   // Outputs
   input wire [6:0] chain_tap,
   input wire [1:0] chain_tile,
   input wire chain_pll_stage,
   input wire ref_route_en,
   input wire [3:0] rpt_marker_word,
   input wire rpt_marker_bad,
   input wire rpt_vld,
   input wire [11:0] target_latency,
   input wire fifo_adj_vld,
   input wire [11:0] fifo_adj_offset,
   input wire busy,
   input wire done,
   input wire scan_fail
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);
   a_start_busy: assert property (!busy && sync_start && tile_sel != 4'h0 |=> busy)
      else $error("start not taken");
   a_route_on: assert property ($rose(busy) |-> ref_route_en)
      else $error("reference not routed");
   a_mid_tap: assert property ($rose(busy) |-> ##[1:3] chain_tap == 7'h40)
      else $error("scan not at midpoint");
   a_ref_default: assert property ($rose(busy) && !clk_forward |-> ##[1:3] chain_tile == ref_tile)
      else $error("wrong reference tile");
   a_done_pulse: assert property (done |=> !done)
      else $error("done too long");
   a_bad_marker: assert property (rpt_vld |-> rpt_marker_bad == (rpt_marker_word > 4'hc))
      else $error("marker flag wrong");
   a_pll_source: assert property (chain_pll_stage |-> pll_mode && busy)
      else $error("stray pll scan");
   a_adj_bound: assert property (fifo_adj_vld |-> busy && fifo_adj_offset <= target_latency)
      else $error("offset too large");
   a_fail_end: assert property ($rose(scan_fail) |-> ##[0:2] done)
      else $error("failure without done");
   c_fail: cover property ($rose(scan_fail));
   c_adj: cover property (fifo_adj_vld);
   c_bad: cover property (rpt_vld && rpt_marker_bad);
endmodule
bind mtsa_top mtsa_top_sva u_sva (.sys_clk, .reset_n, .sync_start,
   .tile_sel, .ref_tile, .clk_forward, .pll_mode, .chain_tap, .chain_tile,
   .chain_pll_stage, .ref_route_en, .rpt_marker_word, .rpt_marker_bad,
   .rpt_vld, .target_latency, .fifo_adj_vld, .fifo_adj_offset, .busy,
   .done, .scan_fail);

// [bench/tb.sv]
// Self-checking bench for the synchronization sequencer
`timescale 1ns/10ps
module tb;
   typedef struct packed {logic [3:0] s; logic f; logic [3:0] m;
      logic p; logic [1:0] r; logic [11:0] td; logic [11:0] t;
      logic [2:0] n;} mtsa_row_t;
   reg sys_clk, reset_n, sync_start, clk_forward, pll_mode;
   reg [3:0] tile_sel, clk_source_mask;
   reg [1:0] ref_tile;
   reg [11:0] target_delay, exp_t;
   reg [4:0] edge_len;
   reg [11:0] lat_of [0:3];
   wire [11:0] fabric_ref_period = 12'h180;
   wire [1:0] chain_tile, chain_sample, rpt_tile, fifo_adj_tile;
   wire [6:0] chain_tap, rpt_tap;
   wire [3:0] marker_word, rpt_marker_word;
   wire [15:0] marker_count, rpt_marker_count;
   wire [11:0] tile_latency, rpt_offset, rpt_ref_period;
   wire [11:0] target_latency, fifo_adj_offset;
   wire chain_pll_stage, ref_route_en, chain_sample_vld, meas_vld, rpt_vld;
   wire rpt_marker_bad, fifo_adj_vld, busy, done, scan_fail;
   integer bad_count = 0, n_checks = 0, n_rpt = 0, n_adj = 0, i;
   mtsa_row_t rows [0:2];
   mtsa_top uut (.*);
   mtsa_far_model far (.*);
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task chk(input ok, input string msg);
   begin
      n_checks++;
      if (ok !== 1'b1)
      begin
         bad_count++;
         $display("BAD %0t %0s", $time, msg);
      end
   end
   endtask
   task close_out;
   begin
      $display("checks %0d bad %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   end
   endtask
   task run(input mtsa_row_t w, input [4:0] e, input h);
      integer c;
   begin
      {tile_sel, clk_forward, clk_source_mask} = {w.s, w.f, w.m};
      {pll_mode, ref_tile, target_delay} = {w.p, w.r, w.td};
      {edge_len, exp_t, n_rpt, n_adj, c} = {e, w.t, 96'h0};
      sync_start = 1'b1;
      @(posedge sys_clk) #1;
      sync_start = h;
      while (done !== 1'b1 && c < 40000)
      begin
         @(posedge sys_clk) #1;
         c++;
      end
      sync_start = 1'b0;
      if (c == 40000)
      begin
         chk(0, "timeout");
         close_out;
      end
   end
   endtask
   always @(posedge sys_clk)
   begin
      if (rpt_vld === 1'b1)
      begin
         lat_of[rpt_tile] = 12'd100 + 12'd8 * n_rpt;
         chk(rpt_marker_word === 4'(4'ha + 2 * n_rpt) && rpt_marker_count
            === 16'd9 + n_rpt && rpt_marker_bad === (n_rpt == 2), "marker");
         n_rpt++;
      end
      if (fifo_adj_vld === 1'b1)
      begin
         chk(fifo_adj_offset === exp_t - lat_of[fifo_adj_tile] &&
            rpt_offset === exp_t - lat_of[fifo_adj_tile], "offset");
         n_adj++;
      end
   end
   initial
   begin
      rows[0] = {4'hf, 1'b0, 4'h0, 1'b0, 2'h0, 12'h000, 12'h07c, 3'h4};
      rows[1] = {4'h5, 1'b1, 4'h4, 1'b1, 2'h0, 12'h000, 12'h06c, 3'h2};
      rows[2] = {4'h3, 1'b0, 4'h0, 1'b0, 2'h1, 12'h0c8, 12'h0c8, 3'h2};
      {reset_n, sync_start, clk_forward, pll_mode} = 4'h0;
      {tile_sel, clk_source_mask, ref_tile} = 10'h0;
      {target_delay, edge_len} = 17'h4;
      repeat (5) @(posedge sys_clk);
      #1 reset_n = 1'b1;
      chk(busy === 1'b0 && done === 1'b0 && chain_tap === 7'h00, "reset");
      for (i = 0; i < 3; i++)
      begin
         run(rows[i], 5'h4, 1'b0);
         chk(target_latency === rows[i].t && scan_fail === 1'b0, "target");
         chk(n_rpt == rows[i].n && n_adj == rows[i].n, "tile count");
         chk(rpt_ref_period === 12'h180, "period");
         chk(rpt_tap === 7'h54, "safe tap");
      end
      run(rows[2], 5'h10, 1'b0);
      chk(scan_fail === 1'b1, "no scan failure");
      run(rows[2], 5'h4, 1'b1);
      chk(n_rpt == 2 && scan_fail === 1'b0, "restart");
      close_out;
   end
endmodule
